// *** verilog/dhbi_pkg.sv ***
// dhbi_pkg: constants shared by the host bus interface of the dual serial controller
// assumes a single 10 MHz core clock
`default_nettype none
package dhbi_pkg;
    localparam int unsigned CLK_PERIOD_NS = 100;
    // index and data widths
    localparam int unsigned INDEX_W = 4;
    localparam int unsigned DATA_W  = 8;
    // ack valid after clock edge, longest time
    localparam int unsigned ACK_DELAY_NS  = 125;
    localparam int unsigned ACK_DELAY_CYC = (ACK_DELAY_NS / CLK_PERIOD_NS) < 1 ? 1 : ACK_DELAY_NS / CLK_PERIOD_NS;
    // quiet gap between writes to one command register, in cycles (three transitions)
    localparam int unsigned CMD_GAP_TRANS = 3;
    localparam int unsigned CMD_GAP_CYC   = (CMD_GAP_TRANS + 1) / 2;
    // command register indices
    localparam logic [3:0] IDX_CHAN_A_CMD = 4'h2;
    localparam logic [3:0] IDX_CHAN_B_CMD = 4'hA;
    // reset value of the data output register
    localparam logic [7:0] DATA_RESET = 8'h00;
    typedef enum logic [1:0] {DHBI_IDLE, DHBI_ACK, DHBI_DONE} dhbi_state_e;
endpackage : dhbi_pkg
`default_nettype wire

// *** verilog/dhbi_sync.sv ***
// dhbi_sync: two-flop synchroniser for one level
// assumes clk and async active-low reset already conditioned
`default_nettype none
module dhbi_sync
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic d,
    input  wire logic init,
    output logic      q
);
    logic meta;
    logic next_meta;
    logic next_q;

    always_comb
    begin
        next_meta = d;
        next_q    = meta;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta <= 1'b1;
            q    <= 1'b1;
        end
        else
        begin
            meta <= next_meta;
            q    <= next_q;
        end
    end
    // init unused in logic: reset value fixed high (strobes idle)
    logic unused_init;
    assign unused_init = init;
endmodule // dhbi_sync
`default_nettype wire

// *** verilog/dhbi_host_bus.sv ***
// dhbi_host_bus: processor bus side of the dual serial controller
// assumes host strobes asynchronous; register core outside answers reads combinationally
// Overview of operation
// (RULE1) acknowledge asserted on a clock edge after select or intr_ack_strobe_n recognised
// (RULE2) late strobe may shift acknowledge by one clock; both allowed
// (RULE3) host holds strobe until acknowledge; early removal may abandon cycle
// (RULE4) write data captured at acknowledge or select removal, whichever first
// (RULE5) select recognised at first edge seen; early removal latches data on removal
// (RULE6) host presents write data before removing select
// (RULE7) host leaves three clock transitions between writes to one command register
// (RULE8) host never asserts select and intr_ack_strobe_n together
// (RULE9) intr_ack_strobe_n cycle ignores read/write line, always a read
// (RULE10) intr_ack_strobe_n drives response byte then acknowledges
// (RULE11) data bus released when read or intr_ack_strobe_n strobe removed
// (RULE12) acknowledge driven inactive then released on strobe removal
// (RULE13) host keeps index and read/write stable across select
// (RULE14) strobes synchronised; index with read/write selects one register
`default_nettype none
module dhbi_host_bus
    import dhbi_pkg::*;
#(
    parameter int unsigned INDEX_W_P = dhbi_pkg::INDEX_W,
    parameter int unsigned DATA_W_P  = dhbi_pkg::DATA_W
)
(
    input  wire logic                   clk,
    input  wire logic                   resetn,
    input  wire logic                   chip_sel_n,
    input  wire logic                   intr_ack_strobe_n,
    input  wire logic                   read_write,
    input  wire logic [INDEX_W_P-1:0]   reg_index,
    input  wire logic [DATA_W_P-1:0]    data_in,
    output logic      [DATA_W_P-1:0]    data_out,
    output logic                        data_oe,
    output logic                        transfer_ack_n,
    output logic                        transfer_ack_oe,
    output logic                        reg_rd,
    output logic                        reg_wr,
    output logic                        intr_ack_cycle,
    output logic      [INDEX_W_P-1:0]   reg_addr,
    output logic      [DATA_W_P-1:0]    wr_data,
    input  wire logic [DATA_W_P-1:0]    rd_data,
    input  wire logic [DATA_W_P-1:0]    intr_vector,
    output logic                        cmd_busy
);
    import dhbi_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // reset release and strobe synchronisers
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    logic cs_s_n;
    logic ia_s_n;
    dhbi_sync u_cs_sync (.clk(clk), .rst_n(rst_n), .d(chip_sel_n), .init(1'b1), .q(cs_s_n)); // RULE14
    dhbi_sync u_ia_sync (.clk(clk), .rst_n(rst_n), .d(intr_ack_strobe_n), .init(1'b1), .q(ia_s_n)); // RULE14

    ////////////////////////////////////////////////////////////////////////
    // cycle state
    dhbi_state_e        state;
    dhbi_state_e        next_state;
    logic               is_intr_ack_strobe_n;
    logic               next_is_intr_ack_strobe_n;
    logic               is_write;
    logic               next_is_write;
    logic [DATA_W_P-1:0] next_data_out;
    logic               next_data_oe;
    logic               next_ack_n;
    logic               next_ack_oe;
    logic               next_reg_rd;
    logic               next_reg_wr;
    logic               next_intr_ack_strobe_n_cycle;
    logic [INDEX_W_P-1:0] next_reg_addr;
    logic [DATA_W_P-1:0]  next_wr_data;
    logic [1:0]         gap_cnt;
    logic [1:0]         next_gap_cnt;
    logic               strobe_on;
    logic               own_strobe;

    assign strobe_on = !cs_s_n || !ia_s_n;
    // a cycle ends only on the strobe that opened it
    assign own_strobe = is_intr_ack_strobe_n ? !ia_s_n : !cs_s_n;

    always_comb
    begin
        next_state      = state;
        next_is_intr_ack_strobe_n    = is_intr_ack_strobe_n;
        next_is_write   = is_write;
        next_data_out   = data_out;
        next_data_oe    = data_oe;
        next_ack_n      = transfer_ack_n;
        next_ack_oe     = transfer_ack_oe;
        next_reg_rd     = 1'b0;
        next_reg_wr     = 1'b0;
        next_intr_ack_strobe_n_cycle = 1'b0;
        next_reg_addr   = reg_addr;
        next_wr_data    = wr_data;
        next_gap_cnt    = (gap_cnt != 2'd0) ? gap_cnt - 2'd1 : 2'd0;
        case (state)
            DHBI_IDLE:
            begin
                next_ack_oe = 1'b0; // RULE12
                if (strobe_on)
                begin
                    // first edge finding strobe low recognises it
                    next_state    = DHBI_ACK; // RULE5
                    next_is_intr_ack_strobe_n  = !ia_s_n;
                    next_is_write = cs_s_n ? 1'b0 : !read_write; // RULE9
                    next_reg_addr = reg_index; // RULE14
                    if (!ia_s_n)
                    begin
                        next_data_out   = intr_vector; // RULE10
                        next_data_oe    = 1'b1; // RULE10
                        next_intr_ack_strobe_n_cycle = 1'b1;
                    end
                    else if (read_write)
                    begin
                        next_data_out = rd_data;
                        next_data_oe  = 1'b1;
                        next_reg_rd   = 1'b1; // RULE14
                    end
                end
            end
            DHBI_ACK:
            begin
                if (!own_strobe)
                begin
                    // strobe left before ack: abandon, still latch write data
                    if (is_write)
                    begin
                        next_wr_data = data_in; // RULE4 RULE5
                        next_reg_wr  = 1'b1;
                    end
                    next_data_oe = 1'b0; // RULE3 RULE11
                    next_state   = DHBI_IDLE;
                end
                else
                begin
                    next_ack_n  = 1'b0; // RULE1 RULE2
                    next_ack_oe = 1'b1; // RULE1
                    if (is_write)
                    begin
                        next_wr_data = data_in; // RULE4
                        next_reg_wr  = 1'b1;
                    end
                    next_state = DHBI_DONE;
                end
                if (is_write && (reg_addr == IDX_CHAN_A_CMD || reg_addr == IDX_CHAN_B_CMD))
                begin
                    next_gap_cnt = 2'(CMD_GAP_CYC);
                end
            end
            DHBI_DONE:
            begin
                if (!own_strobe)
                begin
                    next_data_oe = 1'b0; // RULE11
                    next_ack_n   = 1'b1; // RULE12
                    next_state   = DHBI_IDLE;
                end
            end
            default:
            begin
                next_state = DHBI_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state           <= DHBI_IDLE;
            is_intr_ack_strobe_n         <= 1'b0;
            is_write        <= 1'b0;
            data_out        <= DATA_RESET;
            data_oe         <= 1'b0;
            transfer_ack_n  <= 1'b1;
            transfer_ack_oe <= 1'b0;
            reg_rd          <= 1'b0;
            reg_wr          <= 1'b0;
            intr_ack_cycle  <= 1'b0;
            reg_addr        <= '0;
            wr_data         <= DATA_RESET;
            gap_cnt         <= 2'd0;
        end
        else
        begin
            state           <= next_state;
            is_intr_ack_strobe_n         <= next_is_intr_ack_strobe_n;
            is_write        <= next_is_write;
            data_out        <= next_data_out;
            data_oe         <= next_data_oe;
            transfer_ack_n  <= next_ack_n;
            transfer_ack_oe <= next_ack_oe;
            reg_rd          <= next_reg_rd;
            reg_wr          <= next_reg_wr;
            intr_ack_cycle  <= next_intr_ack_strobe_n_cycle;
            reg_addr        <= next_reg_addr;
            wr_data         <= next_wr_data;
            gap_cnt         <= next_gap_cnt;
        end
    end

    // command register still settling after a write
    assign cmd_busy = (gap_cnt != 2'd0); // RULE7
endmodule // dhbi_host_bus
`default_nettype wire

// *** sim/dhbi_host_bus_properties.sv ***
// dhbi_host_bus_properties: timing checks on the host port
// assumes bound onto dhbi_host_bus, host keeps its pins stable per cycle
`default_nettype none
module dhbi_host_bus_properties
    import dhbi_pkg::*;
#(
    parameter int unsigned INDEX_W_P = 4,
    parameter int unsigned DATA_W_P  = 8
)
(
    input wire logic                 clk,
    input wire logic                 resetn,
    input wire logic                 chip_sel_n,
    input wire logic                 intr_ack_strobe_n,
    input wire logic                 read_write,
    input wire logic [INDEX_W_P-1:0] reg_index,
    input wire logic [DATA_W_P-1:0]  data_in,
    input wire logic [DATA_W_P-1:0]  data_out,
    input wire logic                 data_oe,
    input wire logic                 transfer_ack_n,
    input wire logic                 transfer_ack_oe,
    input wire logic                 reg_rd,
    input wire logic                 reg_wr,
    input wire logic                 intr_ack_cycle,
    input wire logic [INDEX_W_P-1:0] reg_addr,
    input wire logic [DATA_W_P-1:0]  wr_data,
    input wire logic [DATA_W_P-1:0]  rd_data,
    input wire logic [DATA_W_P-1:0]  intr_vector,
    input wire logic                 cmd_busy
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    wire logic idle = chip_sel_n && intr_ack_strobe_n;

    ack_on_strobe_a: assert property ((!idle)[*5] |-> !transfer_ack_n && transfer_ack_oe)
        else $error("no ack");
    ack_held_a: assert property (!transfer_ack_n && !idle |=> !transfer_ack_n)
        else $error("ack dropped");
    ack_release_a: assert property ($rose(transfer_ack_n) |-> transfer_ack_oe ##1 !transfer_ack_oe)
        else $error("ack release order");
    bus_release_a: assert property (idle[*4] |-> !data_oe && transfer_ack_n)
        else $error("bus held");
    intr_ack_strobe_n_byte_a: assert property ($rose(transfer_ack_oe) && !intr_ack_strobe_n |-> data_oe && data_out == intr_vector)
        else $error("intr_ack_strobe_n byte");
    read_byte_a: assert property ($rose(transfer_ack_oe) && !chip_sel_n && read_write |-> data_oe && data_out == rd_data)
        else $error("read byte");
    write_capture_a: assert property (reg_wr |-> !read_write && reg_addr == reg_index && wr_data == data_in ##1 !reg_wr)
        else $error("write capture");
    cmd_busy_a: assert property (reg_wr && (reg_addr == IDX_CHAN_A_CMD || reg_addr == IDX_CHAN_B_CMD) |-> ##[0:1] cmd_busy)
        else $error("no busy");
endmodule // dhbi_host_bus_properties
bind dhbi_host_bus dhbi_host_bus_properties #(.INDEX_W_P(INDEX_W_P), .DATA_W_P(DATA_W_P)) chk_i
(
    .clk               (clk),
    .resetn            (resetn),
    .chip_sel_n        (chip_sel_n),
    .intr_ack_strobe_n (intr_ack_strobe_n),
    .read_write        (read_write),
    .reg_index         (reg_index),
    .data_in           (data_in),
    .data_out          (data_out),
    .data_oe           (data_oe),
    .transfer_ack_n    (transfer_ack_n),
    .transfer_ack_oe   (transfer_ack_oe),
    .reg_rd            (reg_rd),
    .reg_wr            (reg_wr),
    .intr_ack_cycle    (intr_ack_cycle),
    .reg_addr          (reg_addr),
    .wr_data           (wr_data),
    .rd_data           (rd_data),
    .intr_vector       (intr_vector),
    .cmd_busy          (cmd_busy)
);
`default_nettype wire

// *** sim/dhbi_host_model.sv ***
// dhbi_host_model: host processor side of the strobe handshake
// assumes one clock shared with the device
`default_nettype none
module dhbi_host_model
(
    input wire logic       clk,
    input wire logic       transfer_ack_n,
    input wire logic       transfer_ack_oe,
    input wire logic       data_oe,
    input wire logic [7:0] data_out,
    output logic           chip_sel_n,
    output logic           intr_ack_strobe_n,
    output logic           read_write,
    output logic [3:0]     reg_index,
    output logic [7:0]     data_in
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {chip_sel_n, intr_ack_strobe_n, read_write, reg_index, data_in} = 15'h7fff;
    task automatic cycle(input logic ia, rw, input logic [3:0] idx, input logic [7:0] d,
                         input logic abort, output logic acked, output logic [7:0] rd);
        acked = 1'b0;
        @(posedge clk);
        read_write <= rw;
        reg_index <= idx;
        data_in <= d;
        @(posedge clk);
        if (ia) intr_ack_strobe_n <= 1'b0; else chip_sel_n <= 1'b0;
        for (int n = 0; n < 12 && !abort && !acked; n++)
        begin
            @(negedge clk);
            acked = !transfer_ack_n && transfer_ack_oe;
        end
        @(posedge clk);
        // released bus reads back inverted
        rd = data_oe ? data_out : ~data_out;
        chip_sel_n <= 1'b1;
        intr_ack_strobe_n <= 1'b1;
        repeat (6) @(posedge clk);
        data_in <= ~d;
    endtask
endmodule // dhbi_host_model
`default_nettype wire

// *** sim/tb_duart_host_bus_interface.sv ***
// tb_duart_host_bus_interface: random and corner host cycles on the bus port
// assumes the host model and a table of register values stand in for the system
`default_nettype none
module tb_duart_host_bus_interface;
    import dhbi_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic chip_sel_n, intr_ack_strobe_n, read_write, data_oe, transfer_ack_n, transfer_ack_oe;
    logic reg_rd, reg_wr, intr_ack_cycle, cmd_busy;
    logic [3:0] reg_index, reg_addr;
    logic [7:0] data_in, data_out, wr_data, rd_data, rd;
    logic [7:0] last_wr;
    logic [3:0] last_wa;
    int n_busy = 0;
    logic [7:0] intr_vector = 8'h00;
    logic [7:0] core [16];
    logic [31:0] r;
    int seed = 32'h7dc3;
    int num_errors = 0;
    int num_checks = 0;
    int n_wr = 0;
    int n_rd = 0;
    int n_ia = 0;
    assign rd_data = core[reg_index];
    dhbi_host_bus dhbi_host_bus_i
    (
        .clk               (clk),
        .resetn            (resetn),
        .chip_sel_n        (chip_sel_n),
        .intr_ack_strobe_n (intr_ack_strobe_n),
        .read_write        (read_write),
        .reg_index         (reg_index),
        .data_in           (data_in),
        .data_out          (data_out),
        .data_oe           (data_oe),
        .transfer_ack_n    (transfer_ack_n),
        .transfer_ack_oe   (transfer_ack_oe),
        .reg_rd            (reg_rd),
        .reg_wr            (reg_wr),
        .intr_ack_cycle    (intr_ack_cycle),
        .reg_addr          (reg_addr),
        .wr_data           (wr_data),
        .rd_data           (rd_data),
        .intr_vector       (intr_vector),
        .cmd_busy          (cmd_busy)
    );
    dhbi_host_model dhbi_host_model_i
    (
        .clk               (clk),
        .transfer_ack_n    (transfer_ack_n),
        .transfer_ack_oe   (transfer_ack_oe),
        .data_oe           (data_oe),
        .data_out          (data_out),
        .chip_sel_n        (chip_sel_n),
        .intr_ack_strobe_n (intr_ack_strobe_n),
        .read_write        (read_write),
        .reg_index         (reg_index),
        .data_in           (data_in)
    );
    initial forever #50 clk = ~clk;
    always @(posedge clk)
    begin
        if (reg_wr === 1'b1)
        begin
            n_wr++;
            last_wr = wr_data;
            last_wa = reg_addr;
        end
        if (reg_rd === 1'b1) n_rd++;
        if (intr_ack_cycle === 1'b1) n_ia++;
        if (cmd_busy === 1'b1) n_busy++;
    end
    ////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] got, exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    function automatic logic [7:0] exp_byte(input logic ia, input logic [3:0] idx);
        return ia ? intr_vector : core[idx];
    endfunction
    // busy cycles expected after a cycle: only writes to a command register
    function automatic logic [7:0] exp_busy(input logic ia, w, input logic [3:0] idx);
        return (!ia && !w && (idx == IDX_CHAN_A_CMD || idx == IDX_CHAN_B_CMD)) ? 8'(CMD_GAP_CYC) : 8'h00;
    endfunction
    task automatic run(input logic ia, w, input logic [3:0] idx, input logic abort);
        logic       acked;
        logic [7:0] d;
        int w0, r0, i0, b0;
        w0 = n_wr;
        r0 = n_rd;
        i0 = n_ia;
        b0 = n_busy;
        d = 8'($random(seed));
        @(posedge clk);
        intr_vector <= 8'($random(seed));
        dhbi_host_model_i.cycle(ia, w, idx, d, abort, acked, rd);
        if (!abort) check({7'h00, acked}, 8'h01);
        if (!abort && (ia || w)) check(rd, exp_byte(ia, idx));
        if (!ia && !w) check(last_wr, d);
        if (!ia && !w) check({4'h0, last_wa}, {4'h0, idx});
        check(8'(n_busy - b0), exp_busy(ia, w, idx));
        check(8'(n_wr - w0), 8'(!ia && !w));
        check(8'(n_ia - i0), 8'(ia));
        if (!abort) check(8'(n_rd - r0), 8'(!ia && w));
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        for (int i = 0; i < 16; i++) core[i] = 8'($random(seed));
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        run(1'b0, 1'b0, IDX_CHAN_A_CMD, 1'b0);
        run(1'b0, 1'b0, IDX_CHAN_A_CMD, 1'b0);
        run(1'b0, 1'b0, IDX_CHAN_B_CMD, 1'b1);
        run(1'b1, 1'b0, 4'h0, 1'b0);
        run(1'b0, 1'b1, 4'hF, 1'b1);
        repeat (60)
        begin
            r = $random(seed);
            run(r[1:0] == 2'h0, r[2], r[7:4], r[9:8] == 2'h0);
        end
        end_of_test();
    end
    initial
    begin
        repeat (5000) @(posedge clk);
        num_errors++;
        end_of_test();
    end
endmodule // tb_duart_host_bus_interface
`default_nettype wire
